/* evr_cfg_pkg.sv */
package evr_cfg_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Byte offsets on the backplane register port
    localparam logic [7:0] OFS_CHANNEL_SELECT     = 8'h1b;
    localparam logic [7:0] OFS_PULSE_DELAY        = 8'h1c;
    localparam logic [7:0] OFS_PULSE_WIDTH        = 8'h1e;
    localparam logic [7:0] OFS_IRQ_ENABLES        = 8'h23;
    localparam logic [7:0] OFS_OUTPUT_SOURCE      = 8'h25;
    localparam logic [7:0] OFS_BUS_BITS_VIEW      = 8'h27;
    localparam logic [7:0] OFS_PULSE_DIVIDER      = 8'h28;
    localparam logic [7:0] OFS_TIMESTAMP_DIVIDER  = 8'h2a;
    localparam logic [7:0] OFS_FRONT_ONE          = 8'h40;
    localparam logic [7:0] OFS_FRONT_TWO          = 8'h42;
    localparam logic [7:0] OFS_FRONT_THREE        = 8'h44;
    localparam logic [7:0] OFS_SECONDS_SHIFT      = 8'h54;
    localparam logic [7:0] OFS_LATCHED_SECONDS    = 8'h58;
    localparam logic [7:0] OFS_HEAD_SECONDS       = 8'h60;
    localparam logic [7:0] OFS_HEAD_TICKS         = 8'h64;
    localparam logic [7:0] OFS_OUTPUT_POLARITY    = 8'h68;
    localparam logic [7:0] OFS_SYNTH_CONFIG       = 8'h80;

    // Interrupt enable bit positions
    localparam int unsigned BIT_DEFERRED_IRQ   = 4;
    localparam int unsigned BIT_RECEIVED_EVT   = 3;
    localparam int unsigned BIT_HEARTBEAT_LOSS = 2;
    localparam int unsigned BIT_QUEUE_FULL     = 1;
    localparam int unsigned BIT_LINK_VIOLATION = 0;

    // Front-panel source vector layout
    localparam int unsigned SRC_DELAYED_BASE = 0;
    localparam int unsigned SRC_TRIGGER_BASE = 4;
    localparam int unsigned SRC_WIDTH_BASE   = 11;
    localparam int unsigned SRC_LEVEL_BASE   = 25;
    localparam int unsigned SRC_BUS_BASE     = 32;
    localparam int unsigned SRC_PRESC_BASE   = 40;
    localparam int unsigned SRC_COUNT        = 43;
    localparam logic [5:0]  SEL_LAST_CODE    = 6'h2a;

    // Polarity bits that exist: delayed pulses 0-3 and width pulses 0-13
    localparam logic [31:0] POLARITY_MASK = 32'h01fff80f;

    // Reset values
    localparam logic [15:0] RST_VALUE16 = 16'h0000;
    localparam logic [7:0]  RST_VALUE8  = 8'h00;
    localparam logic [31:0] RST_VALUE32 = 32'h0000_0000;

    typedef logic [31:0][15:0] timing_bank_t;

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } reg_req_t;

    typedef struct packed {
        logic deferred;
        logic received_event;
        logic heartbeat_loss;
        logic queue_full;
        logic link_violation;
    } irq_src_t;

    typedef struct packed {
        logic [2:0]  prescaler;
        logic [7:0]  bus_bits;
        logic [6:0]  level;
        logic [13:0] width_pulse;
        logic [6:0]  trigger;
        logic [3:0]  delayed_pulse;
    } pulse_src_t;

    typedef struct packed {
        logic [31:0] seconds_shift;
        logic [31:0] latched_seconds;
        logic [31:0] head_seconds;
        logic [31:0] head_ticks;
    } time_view_t;

endpackage

/* event_receiver_output_config_regs.sv */
`timescale 1ns/1ps

module event_receiver_output_config_regs
(
    input  wire logic                      ref_clk_i,
    input  wire logic                      sys_rst_i,
    input  wire evr_cfg_pkg::reg_req_t     reg_req_i,
    output logic                           rd_valid_o,
    output logic [31:0]                    rd_data_o,
    input  wire evr_cfg_pkg::irq_src_t     irq_src_i,
    input  wire evr_cfg_pkg::pulse_src_t   pulse_src_i,
    input  wire evr_cfg_pkg::time_view_t   time_view_i,
    output logic                           irq_request_o,
    output logic [7:0]                     rear_output_o,
    output logic [2:0]                     front_output_o,
    output evr_cfg_pkg::timing_bank_t      delay_bank_o,
    output evr_cfg_pkg::timing_bank_t      width_bank_o,
    output evr_cfg_pkg::timing_bank_t      divider_bank_o,
    output logic [15:0]                    timestamp_divider_o,
    output logic [31:0]                    synth_config_o
);
    import evr_cfg_pkg::*;

    // Out-of-range codes give zero, so an unused output sits low
    function automatic logic fp_pick(input logic [5:0] sel,
                                     input logic [SRC_COUNT-1:0] src);
        logic pick;
        pick = 1'b0;
        if (sel <= SEL_LAST_CODE)
        begin
            pick = src[sel];
        end
        return pick;
    endfunction

    // Software registers
    logic [4:0]   channel_sel_q, channel_sel_d;
    timing_bank_t delay_q, delay_d;
    timing_bank_t width_q, width_d;
    timing_bank_t divider_q, divider_d;
    logic [7:0]   irq_en_q, irq_en_d;
    logic [7:0]   src_bit_q, src_bit_d;
    logic [15:0]  ts_div_q, ts_div_d;
    logic [5:0]   front_sel_q [3];
    logic [5:0]   front_sel_d [3];
    logic [31:0]  polarity_q, polarity_d;
    logic [31:0]  synth_q, synth_d;

    logic [15:0]  wr16;
    logic [7:0]   wr8;
    assign wr16 = reg_req_i.data[15:0];
    assign wr8  = reg_req_i.data[7:0];

    always_comb
    begin
        channel_sel_d = channel_sel_q;
        delay_d       = delay_q;
        width_d       = width_q;
        divider_d     = divider_q;
        irq_en_d      = irq_en_q;
        src_bit_d     = src_bit_q;
        ts_div_d      = ts_div_q;
        front_sel_d   = front_sel_q;
        polarity_d    = polarity_q;
        synth_d       = synth_q;
        if (reg_req_i.wr)
        begin
            case (reg_req_i.addr)
                OFS_CHANNEL_SELECT:    channel_sel_d = wr8[4:0];
                OFS_PULSE_DELAY:       delay_d[channel_sel_q] = wr16;
                OFS_PULSE_WIDTH:       width_d[channel_sel_q] = wr16;
                OFS_PULSE_DIVIDER:     divider_d[channel_sel_q] = wr16;
                OFS_TIMESTAMP_DIVIDER: ts_div_d = wr16;
                OFS_IRQ_ENABLES:       irq_en_d = {3'h0, wr8[4:0]};
                OFS_OUTPUT_SOURCE:     src_bit_d = wr8;
                OFS_FRONT_ONE:         front_sel_d[0] = wr8[5:0];
                OFS_FRONT_TWO:         front_sel_d[1] = wr8[5:0];
                OFS_FRONT_THREE:       front_sel_d[2] = wr8[5:0];
                OFS_OUTPUT_POLARITY:   polarity_d = reg_req_i.data & POLARITY_MASK;
                OFS_SYNTH_CONFIG:      synth_d = reg_req_i.data;
                // Read-only views such as 0x027 ignore writes
                default:               channel_sel_d = channel_sel_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            channel_sel_q <= '0;
            delay_q       <= '0;
            width_q       <= '0;
            divider_q     <= '0;
            irq_en_q      <= RST_VALUE8;
            src_bit_q     <= RST_VALUE8;
            ts_div_q      <= RST_VALUE16;
            front_sel_q   <= '{default: '0};
            polarity_q    <= RST_VALUE32;
            synth_q       <= RST_VALUE32;
        end
        else
        begin
            channel_sel_q <= channel_sel_d;
            delay_q       <= delay_d;
            width_q       <= width_d;
            divider_q     <= divider_d;
            irq_en_q      <= irq_en_d;
            src_bit_q     <= src_bit_d;
            ts_div_q      <= ts_div_d;
            front_sel_q   <= front_sel_d;
            polarity_q    <= polarity_d;
            synth_q       <= synth_d;
        end
    end

    assign delay_bank_o        = delay_q;
    assign width_bank_o        = width_q;
    assign divider_bank_o      = divider_q;
    assign timestamp_divider_o = ts_div_q;
    assign synth_config_o      = synth_q;

    // Read path; one cycle latency keeps the data bus registered
    logic        rd_valid_q, rd_valid_d;
    logic [31:0] rd_data_q, rd_data_d;

    always_comb
    begin
        rd_valid_d = reg_req_i.rd;
        rd_data_d  = rd_data_q;
        if (reg_req_i.rd)
        begin
            case (reg_req_i.addr)
                OFS_CHANNEL_SELECT:    rd_data_d = {27'h0, channel_sel_q};
                OFS_PULSE_DELAY:       rd_data_d = {16'h0, delay_q[channel_sel_q]};
                OFS_PULSE_WIDTH:       rd_data_d = {16'h0, width_q[channel_sel_q]};
                OFS_PULSE_DIVIDER:     rd_data_d = {16'h0, divider_q[channel_sel_q]};
                OFS_TIMESTAMP_DIVIDER: rd_data_d = {16'h0, ts_div_q};
                OFS_IRQ_ENABLES:       rd_data_d = {24'h0, irq_en_q};
                OFS_OUTPUT_SOURCE:     rd_data_d = {24'h0, src_bit_q};
                OFS_BUS_BITS_VIEW:     rd_data_d = {24'h0, pulse_src_i.bus_bits};
                OFS_FRONT_ONE:         rd_data_d = {26'h0, front_sel_q[0]};
                OFS_FRONT_TWO:         rd_data_d = {26'h0, front_sel_q[1]};
                OFS_FRONT_THREE:       rd_data_d = {26'h0, front_sel_q[2]};
                OFS_SECONDS_SHIFT:     rd_data_d = time_view_i.seconds_shift;
                OFS_LATCHED_SECONDS:   rd_data_d = time_view_i.latched_seconds;
                OFS_HEAD_SECONDS:      rd_data_d = time_view_i.head_seconds;
                OFS_HEAD_TICKS:        rd_data_d = time_view_i.head_ticks;
                OFS_OUTPUT_POLARITY:   rd_data_d = polarity_q;
                OFS_SYNTH_CONFIG:      rd_data_d = synth_q;
                default:               rd_data_d = RST_VALUE32;
            endcase
        end
    end

    // Interrupt gating and output routing
    logic [4:0]           irq_raw;
    logic [SRC_COUNT-1:0] src_vec;
    logic                 irq_d, irq_q;
    logic [7:0]           rear_d, rear_q;
    logic [2:0]           front_d, front_q;

    assign irq_raw = {irq_src_i.deferred, irq_src_i.received_event,
                      irq_src_i.heartbeat_loss, irq_src_i.queue_full,
                      irq_src_i.link_violation};

    always_comb
    begin
        irq_d = |(irq_raw & irq_en_q[4:0]);
        src_vec = pulse_src_i;
        // Levels carry no polarity bit, the mask keeps them untouched
        src_vec[31:0] = src_vec[31:0] ^ (polarity_q & POLARITY_MASK);
        for (int i = 0; i < 8; i++)
        begin
            if (src_bit_q[i])
            begin
                rear_d[i] = pulse_src_i.bus_bits[i];
            end
            else
            begin
                rear_d[i] = src_vec[SRC_WIDTH_BASE + i];
            end
        end
        for (int k = 0; k < 3; k++)
        begin
            front_d[k] = fp_pick(front_sel_q[k], src_vec);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= RST_VALUE32;
            irq_q      <= 1'b0;
            rear_q     <= RST_VALUE8;
            front_q    <= 3'h0;
        end
        else
        begin
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
            irq_q      <= irq_d;
            rear_q     <= rear_d;
            front_q    <= front_d;
        end
    end

    assign rd_valid_o     = rd_valid_q;
    assign rd_data_o      = rd_data_q;
    assign irq_request_o  = irq_q;
    assign rear_output_o  = rear_q;
    assign front_output_o = front_q;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_delay_write;
        logic [4:0] s;
        logic [15:0] v;
        (reg_req_i.wr && reg_req_i.addr == OFS_PULSE_DELAY,
         s = channel_sel_q, v = wr16) |=> delay_bank_o[s] == v;
    endproperty
    a_delay_write: assert property (p_delay_write)
        else $error("delay lost");

    property p_width_write;
        logic [4:0] s;
        logic [15:0] v;
        (reg_req_i.wr && reg_req_i.addr == OFS_PULSE_WIDTH,
         s = channel_sel_q, v = wr16) |=> width_bank_o[s] == v;
    endproperty
    a_width_write: assert property (p_width_write)
        else $error("width lost");

    property p_prescale_write;
        logic [4:0] s;
        logic [15:0] v;
        (reg_req_i.wr && reg_req_i.addr == OFS_PULSE_DIVIDER,
         s = channel_sel_q, v = wr16) |=> divider_bank_o[s] == v;
    endproperty
    a_prescale_write: assert property (p_prescale_write)
        else $error("prescale lost");

    property p_divider_write;
        reg_req_i.wr && reg_req_i.addr == OFS_TIMESTAMP_DIVIDER
            |=> timestamp_divider_o == $past(wr16);
    endproperty
    a_divider_write: assert property (p_divider_write)
        else $error("divider");

    property p_deferred_gated;
        !irq_en_q[BIT_DEFERRED_IRQ] && irq_raw == 5'h10 |=> !irq_request_o;
    endproperty
    a_deferred_gated: assert property (p_deferred_gated)
        else $error("irq leak");

    property p_event_irq;
        irq_en_q[BIT_RECEIVED_EVT] && irq_src_i.received_event
            |=> irq_request_o;
    endproperty
    a_event_irq: assert property (p_event_irq)
        else $error("irq missing");

    // Lone source: the request must follow its enable exactly
    property p_heartbeat_irq;
        logic e;
        (irq_raw == 5'h04, e = irq_en_q[BIT_HEARTBEAT_LOSS])
            |=> irq_request_o == e;
    endproperty
    a_heartbeat_irq: assert property (p_heartbeat_irq)
        else $error("heartbeat irq");

    property p_queue_full_irq;
        logic e;
        (irq_raw == 5'h02, e = irq_en_q[BIT_QUEUE_FULL])
            |=> irq_request_o == e;
    endproperty
    a_queue_full_irq: assert property (p_queue_full_irq)
        else $error("queue full irq");

    property p_violation_irq;
        logic e;
        (irq_raw == 5'h01, e = irq_en_q[BIT_LINK_VIOLATION])
            |=> irq_request_o == e;
    endproperty
    a_violation_irq: assert property (p_violation_irq)
        else $error("violation irq");

    property p_rear_route;
        src_bit_q[0] |=> rear_output_o[0] == $past(pulse_src_i.bus_bits[0]);
    endproperty
    a_rear_route: assert property (p_rear_route)
        else $error("route bad");

    property p_bus_view;
        reg_req_i.rd && reg_req_i.addr == OFS_BUS_BITS_VIEW
            |=> rd_valid_o && rd_data_o == {24'h0, $past(pulse_src_i.bus_bits)};
    endproperty
    a_bus_view: assert property (p_bus_view)
        else $error("bus view");

    property p_front_undefined;
        front_sel_q[0] > SEL_LAST_CODE |=> !front_output_o[0];
    endproperty
    a_front_undefined: assert property (p_front_undefined)
        else $error("fp high");

    property p_front_delayed;
        logic v;
        (front_sel_q[1] == 6'h02 && !polarity_q[2],
         v = pulse_src_i.delayed_pulse[2]) |=> front_output_o[1] == v;
    endproperty
    a_front_delayed: assert property (p_front_delayed)
        else $error("front delayed");

    property p_synth_hold;
        !(reg_req_i.wr && reg_req_i.addr == OFS_SYNTH_CONFIG)
            |=> $stable(synth_config_o);
    endproperty
    a_synth_hold: assert property (p_synth_hold)
        else $error("synth moved");

    property p_reset_clear;
        @(posedge ref_clk_i) $past(sys_rst_i) |-> irq_en_q == 8'h00
            && polarity_q == 32'h0 && !irq_request_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset val");

endmodule

/* host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rd_valid_i,
    input  wire logic [31:0]           rd_data_i,
    output evr_cfg_pkg::reg_req_t      req_o
);
    import evr_cfg_pkg::*;

    initial req_o = '0;

    // Released lines show the inverse, never a stale copy
    task automatic put(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, data: d};
        @(posedge ref_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        put(1'b1, a, d);
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                            output bit ok);
        put(1'b0, a, 32'h0);
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(posedge ref_clk_i);
            ok = (rd_valid_i === 1'b1);
            d  = rd_data_i;
        end
    endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import evr_cfg_pkg::*;

    logic         ref_clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    reg_req_t     req;
    logic         rd_valid;
    logic [31:0]  rd_data;
    irq_src_t     irq_src   = '0;
    pulse_src_t   pulse_src = '0;
    time_view_t   time_view = '0;
    logic         irq_req;
    logic [7:0]   rear;
    logic [2:0]   front;
    timing_bank_t delay_bank;
    timing_bank_t width_bank;
    timing_bank_t divider_bank;
    logic [15:0]  ts_div;
    logic [31:0]  synth;
    int           mismatches = 0;
    int           cmp_count  = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    host_bus_model host (.ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid),
                         .rd_data_i(rd_data), .req_o(req));

    event_receiver_output_config_regs dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .irq_src_i(irq_src),
        .pulse_src_i(pulse_src), .time_view_i(time_view),
        .irq_request_o(irq_req), .rear_output_o(rear),
        .front_output_o(front), .delay_bank_o(delay_bank),
        .width_bank_o(width_bank), .divider_bank_o(divider_bank),
        .timestamp_divider_o(ts_div), .synth_config_o(synth));

    task automatic summarize();
        $display("Counts: %0d compares, %0d mismatches", cmp_count,
                 mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.write_reg(a, d);
    endtask

    // A read that never answers ends the run rather than hanging it
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bit          ok;
        host.read_reg(a, d, ok);
        if (!ok)
        begin
            mismatches++;
            $display("Error at %0t: no answer %h expected %h", $time, a, exp);
            summarize();
        end
        else
        begin
            chk(d, exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk_i);
    endtask

    task automatic test_reset();
        logic [7:0] ofs[$] = '{8'h1b, 8'h1c, 8'h1e, 8'h23, 8'h25, 8'h28,
                               8'h2a, 8'h40, 8'h42, 8'h44, 8'h68, 8'h80,
                               8'h2c};
        foreach (ofs[i])
            rd_chk(ofs[i], 32'h0);
        chk({ts_div, 5'h0, front, rear}, 32'h0);
        chk(synth, 32'h0);
        $display("reset test done");
    endtask

    task automatic test_timing();
        wr(OFS_CHANNEL_SELECT, 32'h2);
        wr(OFS_PULSE_DELAY, 32'h1234);
        wr(OFS_PULSE_WIDTH, 32'h5678);
        wr(OFS_PULSE_DIVIDER, 32'h9abc);
        wr(OFS_CHANNEL_SELECT, 32'h1d);
        wr(OFS_PULSE_DELAY, 32'hffff);
        settle();
        chk({16'h0, delay_bank[2]}, 32'h1234);
        chk({16'h0, width_bank[2]}, 32'h5678);
        chk({16'h0, divider_bank[2]}, 32'h9abc);
        chk({16'h0, delay_bank[29]}, 32'hffff);
        rd_chk(OFS_PULSE_DELAY, 32'hffff);
        wr(OFS_CHANNEL_SELECT, 32'h2);
        rd_chk(OFS_PULSE_DELAY, 32'h1234);
        rd_chk(OFS_PULSE_WIDTH, 32'h5678);
        rd_chk(OFS_PULSE_DIVIDER, 32'h9abc);
        wr(OFS_TIMESTAMP_DIVIDER, 32'h0007);
        wr(OFS_SYNTH_CONFIG, 32'h0c928166);
        settle();
        chk({16'h0, ts_div}, 32'h7);
        chk(synth, 32'h0c928166);
        rd_chk(OFS_SYNTH_CONFIG, 32'h0c928166);
        rd_chk(OFS_TIMESTAMP_DIVIDER, 32'h7);
        $display("timing test done");
    endtask

    task automatic test_irq();
        for (int b = 0; b < 5; b++)
        begin
            wr(OFS_IRQ_ENABLES, 32'h1 << b);
            for (int s = 0; s < 5; s++)
            begin
                @(posedge ref_clk_i);
                irq_src <= irq_src_t'(5'h1 << s);
                settle();
                chk({31'h0, irq_req}, {31'h0, s == b});
            end
        end
        wr(OFS_IRQ_ENABLES, 32'hff);
        rd_chk(OFS_IRQ_ENABLES, 32'h1f);
        wr(OFS_IRQ_ENABLES, 32'h0);
        settle();
        chk({31'h0, irq_req}, 32'h0);
        $display("interrupt test done");
    endtask

    task automatic test_rear();
        pulse_src_t p;
        p             = '0;
        p.width_pulse = 14'h003c;
        p.bus_bits    = 8'h5a;
        @(posedge ref_clk_i);
        pulse_src <= p;
        // Bus and width bits differ under the mask, so a swap shows
        wr(OFS_OUTPUT_SOURCE, 32'h0f);
        settle();
        chk({24'h0, rear}, 32'h5a & 32'h0f | 32'h3c & 32'hf0);
        rd_chk(OFS_BUS_BITS_VIEW, 32'h5a);
        wr(OFS_BUS_BITS_VIEW, 32'hff);
        rd_chk(OFS_BUS_BITS_VIEW, 32'h5a);
        wr(OFS_OUTPUT_SOURCE, 32'h0);
        wr(OFS_OUTPUT_POLARITY, 32'h800);
        settle();
        chk({24'h0, rear}, 32'h3d);
        wr(OFS_OUTPUT_POLARITY, 32'hffffffff);
        rd_chk(OFS_OUTPUT_POLARITY, POLARITY_MASK);
        wr(OFS_OUTPUT_POLARITY, 32'h0);
        $display("rear output test done");
    endtask

    task automatic test_front();
        for (int c = 0; c < 64; c++)
        begin
            wr(OFS_FRONT_ONE, 32'(c));
            wr(OFS_FRONT_TWO, 32'(c));
            wr(OFS_FRONT_THREE, 32'(c));
            @(posedge ref_clk_i);
            pulse_src <= pulse_src_t'(43'h1 << c);
            settle();
            chk({29'h0, front}, c < 43 ? 32'h7 : 32'h0);
            @(posedge ref_clk_i);
            pulse_src <= pulse_src_t'(~(43'h1 << c));
            settle();
            chk({29'h0, front}, 32'h0);
        end
        rd_chk(OFS_FRONT_TWO, 32'h3f);
        @(posedge ref_clk_i);
        pulse_src <= '0;
        wr(OFS_FRONT_ONE, 32'h0);
        wr(OFS_OUTPUT_POLARITY, 32'h1);
        settle();
        chk({29'h0, front}, 32'h1);
        $display("front output test done");
    endtask

    task automatic test_time();
        @(posedge ref_clk_i);
        time_view <= '{32'h1, 32'h2, 32'h12345678, 32'h9abcdef0};
        wr(OFS_HEAD_SECONDS, 32'h0);
        rd_chk(OFS_HEAD_SECONDS, 32'h12345678);
        rd_chk(OFS_HEAD_TICKS, 32'h9abcdef0);
        $display("time view test done");
    endtask

    // Reset in mid-run with live state and an active source
    task automatic test_mid_reset();
        wr(OFS_IRQ_ENABLES, 32'h1f);
        wr(OFS_SYNTH_CONFIG, 32'h0c928166);
        settle();
        chk({31'h0, irq_req}, 32'h1);
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        test_reset();
        $display("mid-run reset test done");
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        test_reset();
        test_timing();
        test_irq();
        test_rear();
        test_front();
        test_time();
        test_mid_reset();
        summarize();
    end
endmodule
